// ===== pkg/cpu_flags_pkg.sv
// Constants, field positions and operation codes for the flags/IP block
package cpu_flags_pkg;

  // Flag bit positions within the 32-bit flags register
  localparam int CARRY_POS = 0;
  localparam int FIXED_ONE_POS = 1;
  localparam int PARITY_POS = 2;
  localparam int AUX_POS = 4;
  localparam int ZERO_POS = 6;
  localparam int SIGN_POS = 7;
  localparam int TRAP_POS = 8;
  localparam int INT_EN_POS = 9;
  localparam int DIR_POS = 10;
  localparam int OVF_POS = 11;
  localparam int IO_PRIVILEGE_LEVEL_LO_POS = 12;
  localparam int IO_PRIVILEGE_LEVEL_HI_POS = 13;
  localparam int NESTED_POS = 14;
  localparam int RESUME_POS = 16;
  localparam int V86_POS = 17;
  localparam int ALIGN_POS = 18;
  localparam int VIF_POS = 19;
  localparam int VIP_POS = 20;
  localparam int QUERY_POS = 21;

  // Widths
  localparam int FLAGS_W = 32;
  localparam int WIDE_W = 64;
  localparam int DATA_W = 64;

  // Value after reset or init, and bits that may ever hold a one
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  localparam logic [31:0] FLAGS_WRITABLE = 32'h003f_7fd5;
  localparam logic [31:0] FLAGS_FIXED = 32'h0000_0002;
  localparam logic [63:0] IP_RESET = 64'h0000_0000_0000_0000;
  localparam logic [1:0] PRIV_TOP = 2'h0;

  // Operations presented to the block, one per retired instruction
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_LOGIC,
    OP_SET_CARRY, OP_CLEAR_CARRY, OP_INVERT_CARRY,
    OP_SET_DIR, OP_CLEAR_DIR, OP_BIT_TEST,
    OP_POP_FLAGS, OP_INT_RETURN, OP_TASK_LINK
  } op_e;

  // Operand size
  typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32, SZ_64} size_e;

endpackage : cpu_flags_pkg

// ===== src/status_flag_calc.sv
// Arithmetic result and status flag derivation for one operation
`timescale 1ns/1ps
module status_flag_calc (
  input wire cpu_flags_pkg::op_e op_in,
  input wire cpu_flags_pkg::size_e size_in,
  input wire logic [63:0] opa_in,
  input wire logic [63:0] opb_in,
  input wire logic carry_in,
  output logic [63:0] result_out,
  output logic carry_out,
  output logic parity_out,
  output logic aux_out,
  output logic zero_out,
  output logic sign_out,
  output logic ovf_out
);

  // Mask of the live bits for an operand size
  function automatic logic [63:0] size_mask(cpu_flags_pkg::size_e s);
    case (s)
      cpu_flags_pkg::SZ_8: size_mask = 64'h0000_0000_0000_00ff;
      cpu_flags_pkg::SZ_16: size_mask = 64'h0000_0000_0000_ffff;
      cpu_flags_pkg::SZ_32: size_mask = 64'h0000_0000_ffff_ffff;
      default: size_mask = 64'hffff_ffff_ffff_ffff;
    endcase
  endfunction : size_mask

  logic [63:0] msk;
  logic [63:0] a_m;
  logic [63:0] b_m;
  logic [64:0] sum;
  logic is_sub;
  logic cin;
  int top;

  // Add or subtract at the chosen width, then derive each flag
  always_comb begin
    msk = size_mask(size_in);
    top = (8 << size_in) - 1;
    is_sub = (op_in == cpu_flags_pkg::OP_SUB) ||
             (op_in == cpu_flags_pkg::OP_SBB);
    cin = ((op_in == cpu_flags_pkg::OP_ADC) ||
           (op_in == cpu_flags_pkg::OP_SBB)) && carry_in;
    a_m = opa_in & msk;
    b_m = (is_sub ? ~opb_in : opb_in) & msk;
    sum = {1'b0, a_m} + {1'b0, b_m} + {64'h0, is_sub ^ cin};
    if (op_in == cpu_flags_pkg::OP_LOGIC) begin
      result_out = opa_in & opb_in & msk;
    end else begin
      result_out = sum[63:0] & msk;
    end
    // Carry or borrow out of the top live bit
    carry_out = (op_in != cpu_flags_pkg::OP_LOGIC) &&
                (sum[top + 1] ^ is_sub);
    parity_out = ~^result_out[7:0];
    aux_out = (op_in != cpu_flags_pkg::OP_LOGIC) &&
              (opa_in[4] ^ opb_in[4] ^ result_out[4]);
    zero_out = (result_out == 64'h0);
    sign_out = result_out[top];
    ovf_out = (op_in != cpu_flags_pkg::OP_LOGIC) &&
              (a_m[top] == b_m[top]) &&
              (result_out[top] != a_m[top]);
  end

endmodule : status_flag_calc

// ===== src/instr_pointer_calc.sv
// Next instruction pointer and pointer-relative address
`timescale 1ns/1ps
module instr_pointer_calc (
  input wire logic [63:0] ip_in,
  input wire logic wide_mode_in,
  input wire logic advance_in,
  input wire logic [3:0] len_in,
  input wire logic redirect_in,
  input wire logic [63:0] target_in,
  input wire logic [31:0] disp_in,
  output logic [63:0] next_ip_out,
  output logic [63:0] rel_addr_out
);

  logic [63:0] seq;

  // Straight-line advance or control-transfer redirect
  always_comb begin
    seq = ip_in + {60'h0, len_in};
    if (!advance_in) begin
      next_ip_out = ip_in;
    end else if (redirect_in) begin
      next_ip_out = target_in;
    end else begin
      next_ip_out = seq;
    end
    if (!wide_mode_in) begin
      next_ip_out = {32'h0, next_ip_out[31:0]};
    end
    // Displacement added to the pointer of the following instruction
    rel_addr_out = seq + {{32{disp_in[31]}}, disp_in};
    if (!wide_mode_in) begin
      rel_addr_out = {32'h0, rel_addr_out[31:0]};
    end
  end

endmodule : instr_pointer_calc

// ===== src/cpu_flags_ip.sv
// Flags register and instruction pointer of the processor core
// What this block does
// - Carry flag bit 0 set on carry or borrow out of top bit.
// - Parity flag set when low result byte has even count of ones.
// - Auxiliary carry set on carry or borrow out of bit 3.
// - Zero flag set exactly when the whole result is zero.
// - Sign flag copies the result's top bit.
// - Overflow flag set when signed result does not fit destination.
// - Status flags sit at bits 0, 2, 4, 6, 7 and 11.
// - Only carry is set, cleared, inverted directly; bit test loads it.
// - Add-with-carry and subtract-with-borrow consume the current carry.
// - Direction flag bit 10 picks decrement or increment; set/clear ops.
// - Trap flag set gives single-step mode; clear leaves it.
// - Interrupt enable bit 9 accepts or inhibits maskable interrupts.
// - I/O privilege bits 12-13 gate I/O; changed only at privilege 0.
// - Nested task bit 14 follows linkage to the previous task.
// - Resume flag bit 16 governs the response to debug exceptions.
// - Bit 17 selects virtual-8086 mode.
// - Alignment checks need bit 18 and the control alignment mask.
// - Bits 19/20 virtual interrupt copy and pending, used with extension.
// - Bit 21 is freely writable so identification support is visible.
// - Wide flags are 64 bits, upper half reserved zero.
// - Pointer advances sequentially or redirects; no software access.
// - Wide pointer is 64 bits; relative address is disp plus next ip.
// - Reset or init gives flags 00000002H; reserved bits stay fixed.
`timescale 1ns/1ps
module cpu_flags_ip (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic init_in,
  input wire logic op_valid_in,
  input wire cpu_flags_pkg::op_e op_in,
  input wire cpu_flags_pkg::size_e size_in,
  input wire logic [63:0] opa_in,
  input wire logic [63:0] opb_in,
  input wire logic [5:0] bit_sel_in,
  input wire logic [31:0] pop_value_in,
  input wire logic task_linked_in,
  input wire logic [1:0] current_priv_level_in,
  input wire logic align_mask_ctl_in,
  input wire logic virt_mode_ext_in,
  input wire logic wide_mode_in,
  input wire logic [3:0] instr_len_in,
  input wire logic redirect_in,
  input wire logic [63:0] redirect_target_in,
  input wire logic [31:0] disp_in,
  input wire logic intr_req_in,
  input wire logic breakpoint_in,
  output logic [63:0] result_out,
  output logic [63:0] wide_flags_out,
  output logic [63:0] instr_pointer_out,
  output logic [63:0] rel_addr_out,
  output logic [7:0] string_step_out,
  output logic single_step_trap_out,
  output logic int_accept_out,
  output logic debug_trap_out,
  output logic io_allowed_out,
  output logic align_check_en_out,
  output logic v86_mode_out,
  output logic virt_int_pending_out
);

  typedef struct packed {
    logic [31:0] flags;
    logic [63:0] ip;
    logic [63:0] result;
    logic [63:0] rel_addr;
    logic [7:0] string_step;
    logic step_trap;
    logic int_accept;
    logic debug_trap;
    logic io_ok;
    logic align_en;
    logic virt_pend;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic [63:0] alu_res;
  logic alu_cf, alu_pf, alu_af, alu_zf, alu_sf, alu_of;
  logic [63:0] next_ip;
  logic [63:0] rel_addr;
  logic arith;
  logic [31:0] merged;
  logic [31:0] keep_mask;

  status_flag_calc u_flag_calc (
    .op_in(op_in),
    .size_in(size_in),
    .opa_in(opa_in),
    .opb_in(opb_in),
    .carry_in(st_q.flags[cpu_flags_pkg::CARRY_POS]),
    .result_out(alu_res),
    .carry_out(alu_cf),
    .parity_out(alu_pf),
    .aux_out(alu_af),
    .zero_out(alu_zf),
    .sign_out(alu_sf),
    .ovf_out(alu_of)
  );

  instr_pointer_calc u_ip_calc (
    .ip_in(st_q.ip),
    .wide_mode_in(wide_mode_in),
    .advance_in(op_valid_in),
    .len_in(instr_len_in),
    .redirect_in(redirect_in),
    .target_in(redirect_target_in),
    .disp_in(disp_in),
    .next_ip_out(next_ip),
    .rel_addr_out(rel_addr)
  );

  // Next state: flag updates per retired operation, then derived outputs
  always_comb begin
    st_d = st_q;
    arith = (op_in == cpu_flags_pkg::OP_ADD) ||
            (op_in == cpu_flags_pkg::OP_ADC) ||
            (op_in == cpu_flags_pkg::OP_SUB) ||
            (op_in == cpu_flags_pkg::OP_SBB) ||
            (op_in == cpu_flags_pkg::OP_LOGIC);
    // Bits that a flag load from the stack must not touch
    keep_mask = 32'h0;
    if (current_priv_level_in != cpu_flags_pkg::PRIV_TOP) begin
      keep_mask[cpu_flags_pkg::IO_PRIVILEGE_LEVEL_HI_POS:cpu_flags_pkg::IO_PRIVILEGE_LEVEL_LO_POS] =
        2'h3;
    end
    if (op_in == cpu_flags_pkg::OP_POP_FLAGS) begin
      keep_mask[cpu_flags_pkg::RESUME_POS] = 1'b1;
      keep_mask[cpu_flags_pkg::V86_POS] = 1'b1;
    end
    merged = (st_q.flags & keep_mask) | (pop_value_in & ~keep_mask);
    st_d.debug_trap = 1'b0;
    st_d.step_trap = 1'b0;
    if (op_valid_in) begin
      st_d.ip = next_ip;
      st_d.rel_addr = rel_addr;
      case (op_in)
        cpu_flags_pkg::OP_ADD, cpu_flags_pkg::OP_ADC,
        cpu_flags_pkg::OP_SUB, cpu_flags_pkg::OP_SBB,
        cpu_flags_pkg::OP_LOGIC: begin
          st_d.result = alu_res;
          st_d.flags[cpu_flags_pkg::CARRY_POS] = alu_cf;
          st_d.flags[cpu_flags_pkg::PARITY_POS] = alu_pf;
          st_d.flags[cpu_flags_pkg::AUX_POS] = alu_af;
          st_d.flags[cpu_flags_pkg::ZERO_POS] = alu_zf;
          st_d.flags[cpu_flags_pkg::SIGN_POS] = alu_sf;
          st_d.flags[cpu_flags_pkg::OVF_POS] = alu_of;
        end
        cpu_flags_pkg::OP_SET_CARRY: begin
          st_d.flags[cpu_flags_pkg::CARRY_POS] = 1'b1;
        end
        cpu_flags_pkg::OP_CLEAR_CARRY: begin
          st_d.flags[cpu_flags_pkg::CARRY_POS] = 1'b0;
        end
        cpu_flags_pkg::OP_INVERT_CARRY: begin
          st_d.flags[cpu_flags_pkg::CARRY_POS] =
            ~st_q.flags[cpu_flags_pkg::CARRY_POS];
        end
        cpu_flags_pkg::OP_BIT_TEST: begin
          st_d.flags[cpu_flags_pkg::CARRY_POS] = opa_in[bit_sel_in];
        end
        cpu_flags_pkg::OP_SET_DIR: begin
          st_d.flags[cpu_flags_pkg::DIR_POS] = 1'b1;
        end
        cpu_flags_pkg::OP_CLEAR_DIR: begin
          st_d.flags[cpu_flags_pkg::DIR_POS] = 1'b0;
        end
        cpu_flags_pkg::OP_POP_FLAGS, cpu_flags_pkg::OP_INT_RETURN: begin
          // Software image load; bit 21 and bit 20 are plain storage
          st_d.flags = merged;
        end
        cpu_flags_pkg::OP_TASK_LINK: begin
          st_d.flags[cpu_flags_pkg::NESTED_POS] = task_linked_in;
        end
        default: begin
          st_d.flags = st_q.flags;
        end
      endcase
      // Single-step trap after each instruction retired with trap set
      st_d.step_trap = st_q.flags[cpu_flags_pkg::TRAP_POS];
      // Resume flag lasts for one retired instruction
      if (op_in != cpu_flags_pkg::OP_POP_FLAGS &&
          op_in != cpu_flags_pkg::OP_INT_RETURN) begin
        st_d.flags[cpu_flags_pkg::RESUME_POS] = 1'b0;
      end
    end
    // Reserved bits are forced on every update
    st_d.flags = (st_d.flags & cpu_flags_pkg::FLAGS_WRITABLE) |
                 cpu_flags_pkg::FLAGS_FIXED;
    if (init_in) begin
      st_d.flags = cpu_flags_pkg::FLAGS_RESET;
      st_d.ip = cpu_flags_pkg::IP_RESET;
    end
    // Breakpoint is suppressed while resume is set
    st_d.debug_trap = breakpoint_in &&
                      !st_q.flags[cpu_flags_pkg::RESUME_POS];
    st_d.int_accept = intr_req_in &&
                      st_q.flags[cpu_flags_pkg::INT_EN_POS];
    st_d.io_ok = current_priv_level_in <=
      st_q.flags[cpu_flags_pkg::IO_PRIVILEGE_LEVEL_HI_POS:cpu_flags_pkg::IO_PRIVILEGE_LEVEL_LO_POS];
    st_d.align_en = st_q.flags[cpu_flags_pkg::ALIGN_POS] &&
                    align_mask_ctl_in;
    st_d.virt_pend = virt_mode_ext_in &&
                     st_q.flags[cpu_flags_pkg::VIF_POS] &&
                     st_q.flags[cpu_flags_pkg::VIP_POS];
    // String address step, negative when direction is set
    st_d.string_step = st_q.flags[cpu_flags_pkg::DIR_POS] ?
      8'(-(8'h1 << size_in)) : 8'(8'h1 << size_in);
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '0;
      st_q.flags <= cpu_flags_pkg::FLAGS_RESET;
      st_q.ip <= cpu_flags_pkg::IP_RESET;
      st_q.string_step <= 8'h01;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign result_out = st_q.result;
  assign wide_flags_out = {32'h0, st_q.flags};
  assign instr_pointer_out = st_q.ip;
  assign rel_addr_out = st_q.rel_addr;
  assign string_step_out = st_q.string_step;
  assign single_step_trap_out = st_q.step_trap;
  assign int_accept_out = st_q.int_accept;
  assign debug_trap_out = st_q.debug_trap;
  assign io_allowed_out = st_q.io_ok;
  assign align_check_en_out = st_q.align_en;
  assign v86_mode_out = st_q.flags[cpu_flags_pkg::V86_POS];
  assign virt_int_pending_out = st_q.virt_pend;

  // Checks
  AST_SET_CARRY: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && op_in == cpu_flags_pkg::OP_SET_CARRY && !init_in
    |=> wide_flags_out[0]) else $error("carry not set");
  AST_INV_CARRY: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && op_in == cpu_flags_pkg::OP_INVERT_CARRY && !init_in
    |=> wide_flags_out[0] != $past(wide_flags_out[0]))
    else $error("carry not inverted");
  AST_ADD_CARRY: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && op_in == cpu_flags_pkg::OP_ADD &&
    size_in == cpu_flags_pkg::SZ_8 && !init_in
    |=> wide_flags_out[0] == $past(9'(opa_in[7:0]) + 9'(opb_in[7:0]) > 9'hff))
    else $error("byte add carry wrong");
  AST_ZERO: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && arith && !init_in
    |=> wide_flags_out[6] == (result_out == 64'h0))
    else $error("zero flag mismatch");
  AST_PARITY: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && arith && !init_in
    |=> wide_flags_out[2] == ~^result_out[7:0])
    else $error("parity flag mismatch");
  AST_RESERVED: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (wide_flags_out & ~{32'h0, cpu_flags_pkg::FLAGS_WRITABLE}) == 64'h2)
    else $error("reserved flag bits wrong");
  AST_INIT: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    init_in |=> wide_flags_out == 64'h2) else $error("init value");
  AST_IO_PRIVILEGE_LEVEL_HOLD: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    current_priv_level_in != 2'h0 && !init_in
    |=> $stable(wide_flags_out[13:12]))
    else $error("privilege field changed");
  AST_INT_GATE: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    intr_req_in && !wide_flags_out[9] |=> !int_accept_out)
    else $error("interrupt taken while masked");
  AST_ALIGN: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    align_check_en_out |->
    $past(align_mask_ctl_in) && $past(wide_flags_out[18]))
    else $error("alignment check without both enables");
  AST_IP_SEQ: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && !redirect_in && !init_in && wide_mode_in
    |=> instr_pointer_out ==
    $past(instr_pointer_out) + 64'($past(instr_len_in)))
    else $error("pointer did not advance");
  AST_STEP: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && wide_flags_out[8] |=> single_step_trap_out ##1
    (single_step_trap_out == $past(op_valid_in && wide_flags_out[8])))
    else $error("single-step trap missing");
  AST_RESUME: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    breakpoint_in && wide_flags_out[16] |=> !debug_trap_out)
    else $error("breakpoint taken while resume set");
  AST_DIR_STEP: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    wide_flags_out[10] |=> string_step_out[7])
    else $error("string step not negative");
  AST_IO_GATE: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    io_allowed_out |->
    $past(current_priv_level_in) <= $past(wide_flags_out[13:12]))
    else $error("io allowed above privilege field");
  AST_NEST: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && op_in == cpu_flags_pkg::OP_TASK_LINK && !init_in
    |=> wide_flags_out[14] == $past(task_linked_in))
    else $error("nested task flag wrong");

  COV_ADC: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && op_in == cpu_flags_pkg::OP_ADC && wide_flags_out[0]);
  COV_POP: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && op_in == cpu_flags_pkg::OP_POP_FLAGS);
  COV_REDIRECT: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    op_valid_in && redirect_in);
  COV_OVF: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    wide_flags_out[11]);
  COV_RESUME: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    breakpoint_in && wide_flags_out[16]);

endmodule : cpu_flags_ip

// ===== tb/cpu_flags_ip_tb.sv
// Self-checking testbench for the flags register and instruction pointer
`timescale 1ns/1ps
module cpu_flags_ip_tb;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic init_in = 1'b0;
  logic op_valid_in = 1'b0;
  cpu_flags_pkg::op_e op_in = cpu_flags_pkg::OP_NONE;
  cpu_flags_pkg::size_e size_in = cpu_flags_pkg::SZ_8;
  logic [63:0] opa_in = 64'h0;
  logic [63:0] opb_in = 64'h0;
  logic [5:0] bit_sel_in = 6'h0;
  logic [31:0] pop_value_in = 32'h0;
  logic task_linked_in = 1'b0;
  logic [1:0] current_priv_level_in = 2'h0;
  logic align_mask_ctl_in = 1'b0;
  logic virt_mode_ext_in = 1'b0;
  logic wide_mode_in = 1'b1;
  logic [3:0] instr_len_in = 4'h2;
  logic redirect_in = 1'b0;
  logic [63:0] redirect_target_in = 64'h0;
  logic [31:0] disp_in = 32'h0;
  logic intr_req_in = 1'b0;
  logic breakpoint_in = 1'b0;
  logic [63:0] result_out, wide_flags_out, instr_pointer_out, rel_addr_out;
  logic [7:0] string_step_out;
  logic single_step_trap_out, int_accept_out, debug_trap_out;
  logic io_allowed_out, align_check_en_out, v86_mode_out;
  logic virt_int_pending_out;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  // Pointer-related values copied onto the pins with each operation
  logic [3:0] len_v = 4'h2;
  logic [31:0] disp_v = 32'h0;
  logic redir_v = 1'b0;
  logic [63:0] tgt_v = 64'h0;

  cpu_flags_ip cpu_flags_ip_inst (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .init_in(init_in),
    .op_valid_in(op_valid_in), .op_in(op_in), .size_in(size_in),
    .opa_in(opa_in), .opb_in(opb_in), .bit_sel_in(bit_sel_in),
    .pop_value_in(pop_value_in), .task_linked_in(task_linked_in),
    .current_priv_level_in(current_priv_level_in),
    .align_mask_ctl_in(align_mask_ctl_in),
    .virt_mode_ext_in(virt_mode_ext_in), .wide_mode_in(wide_mode_in),
    .instr_len_in(instr_len_in), .redirect_in(redirect_in),
    .redirect_target_in(redirect_target_in), .disp_in(disp_in),
    .intr_req_in(intr_req_in), .breakpoint_in(breakpoint_in),
    .result_out(result_out), .wide_flags_out(wide_flags_out),
    .instr_pointer_out(instr_pointer_out), .rel_addr_out(rel_addr_out),
    .string_step_out(string_step_out),
    .single_step_trap_out(single_step_trap_out),
    .int_accept_out(int_accept_out), .debug_trap_out(debug_trap_out),
    .io_allowed_out(io_allowed_out),
    .align_check_en_out(align_check_en_out),
    .v86_mode_out(v86_mode_out),
    .virt_int_pending_out(virt_int_pending_out)
  );

  // Core clock, 100 ns period
  always #50 clk_sys_in = ~clk_sys_in;

  // Cut a hung run short
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      $display("mismatch at %0t: run did not finish in time", $time);
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : chk

  // One retired operation; returns once its results have landed
  task automatic do_op(input cpu_flags_pkg::op_e o,
                       input cpu_flags_pkg::size_e s,
                       input logic [63:0] a, input logic [63:0] b,
                       input logic [31:0] pv);
    @(posedge clk_sys_in);
    op_valid_in <= 1'b1;
    op_in <= o;
    size_in <= s;
    opa_in <= a;
    opb_in <= b;
    bit_sel_in <= b[5:0];
    pop_value_in <= pv;
    task_linked_in <= pv[0];
    instr_len_in <= len_v;
    disp_in <= disp_v;
    redirect_in <= redir_v;
    redirect_target_in <= tgt_v;
    @(posedge clk_sys_in);
    op_valid_in <= 1'b0;
    #1;
  endtask : do_op

  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask : tick

  task automatic test_reset();
    chk(wide_flags_out, 64'h2, "flags in reset");
    chk(instr_pointer_out, 64'h0, "pointer in reset");
    chk(string_step_out, 8'h01, "step in reset");
  endtask : test_reset

  // Status flags, compared under the mask of the six status bits
  task automatic test_arith();
    do_op(cpu_flags_pkg::OP_ADD, cpu_flags_pkg::SZ_8, 64'hff, 64'h01, 0);
    chk(result_out, 64'h0, "add8 result");
    chk(wide_flags_out & 64'h8d5, 64'h055, "add8 wrap");
    do_op(cpu_flags_pkg::OP_ADD, cpu_flags_pkg::SZ_8, 64'h7f, 64'h01, 0);
    chk(result_out, 64'h80, "add8 overflow result");
    chk(wide_flags_out & 64'h8d5, 64'h890, "add8 signed overflow");
    do_op(cpu_flags_pkg::OP_SUB, cpu_flags_pkg::SZ_8, 64'h00, 64'h01, 0);
    chk(result_out, 64'hff, "sub8 result");
    chk(wide_flags_out & 64'h8d5, 64'h095, "sub8 borrow");
    do_op(cpu_flags_pkg::OP_ADD, cpu_flags_pkg::SZ_64, '1, 64'h1, 0);
    chk(wide_flags_out & 64'h8d5, 64'h055, "add64 carry");
    do_op(cpu_flags_pkg::OP_LOGIC, cpu_flags_pkg::SZ_8, 64'hf0, 64'h3c, 0);
    chk(result_out, 64'h30, "and result");
    chk(wide_flags_out & 64'h8d5, 64'h004, "and flags");
  endtask : test_arith

  task automatic test_carry_ops();
    do_op(cpu_flags_pkg::OP_SET_CARRY, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(wide_flags_out[0], 1'b1, "set carry");
    do_op(cpu_flags_pkg::OP_ADC, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(result_out, 64'h1, "adc uses carry");
    do_op(cpu_flags_pkg::OP_SET_CARRY, cpu_flags_pkg::SZ_8, 0, 0, 0);
    do_op(cpu_flags_pkg::OP_SBB, cpu_flags_pkg::SZ_8, 64'h5, 64'h2, 0);
    chk(result_out, 64'h2, "sbb uses borrow");
    do_op(cpu_flags_pkg::OP_CLEAR_CARRY, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(wide_flags_out[0], 1'b0, "clear carry");
    do_op(cpu_flags_pkg::OP_INVERT_CARRY, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(wide_flags_out[0], 1'b1, "invert carry");
    do_op(cpu_flags_pkg::OP_BIT_TEST, cpu_flags_pkg::SZ_8, 64'h10, 64'h3, 0);
    chk(wide_flags_out[0], 1'b0, "bit test clear bit");
    do_op(cpu_flags_pkg::OP_BIT_TEST, cpu_flags_pkg::SZ_8, 64'h10, 64'h4, 0);
    chk(wide_flags_out[0], 1'b1, "bit test set bit");
  endtask : test_carry_ops

  task automatic test_direction();
    do_op(cpu_flags_pkg::OP_SET_DIR, cpu_flags_pkg::SZ_32, 0, 0, 0);
    chk(wide_flags_out[10], 1'b1, "set direction");
    tick();
    chk(string_step_out, 8'hfc, "decrement step");
    do_op(cpu_flags_pkg::OP_CLEAR_DIR, cpu_flags_pkg::SZ_16, 0, 0, 0);
    chk(wide_flags_out[10], 1'b0, "clear direction");
    tick();
    chk(string_step_out, 8'h02, "increment step");
  endtask : test_direction

  // Flags image loads, privilege gating and the derived controls
  task automatic test_system();
    @(posedge clk_sys_in);
    current_priv_level_in <= 2'h0;
    intr_req_in <= 1'b1;
    align_mask_ctl_in <= 1'b1;
    virt_mode_ext_in <= 1'b1;
    breakpoint_in <= 1'b1;
    do_op(cpu_flags_pkg::OP_POP_FLAGS, cpu_flags_pkg::SZ_32, 0, 0, '1);
    chk(wide_flags_out, 64'h3c_7fd7, "pop all ones");
    tick();
    chk(int_accept_out, 1'b1, "interrupt accepted");
    chk(io_allowed_out, 1'b1, "io at level 0");
    chk(align_check_en_out, 1'b1, "alignment on");
    chk(virt_int_pending_out, 1'b1, "virtual pending");
    chk(debug_trap_out, 1'b1, "debug trap");
    chk(v86_mode_out, 1'b0, "v86 kept clear");
    do_op(cpu_flags_pkg::OP_NONE, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(single_step_trap_out, 1'b1, "single step");
    @(posedge clk_sys_in);
    align_mask_ctl_in <= 1'b0;
    current_priv_level_in <= 2'h3;
    tick();
    chk(align_check_en_out, 1'b0, "alignment masked");
    chk(io_allowed_out, 1'b1, "io at equal level");
    do_op(cpu_flags_pkg::OP_INT_RETURN, cpu_flags_pkg::SZ_32, 0, 0, 0);
    chk(wide_flags_out, 64'h3002, "io field held at level 3");
    tick();
    chk(int_accept_out, 1'b0, "interrupt inhibited");
    chk(virt_int_pending_out, 1'b0, "virtual pending off");
    chk(single_step_trap_out, 1'b0, "no step pulse");
    @(posedge clk_sys_in);
    current_priv_level_in <= 2'h0;
    do_op(cpu_flags_pkg::OP_POP_FLAGS, cpu_flags_pkg::SZ_32, 0, 0, 0);
    chk(wide_flags_out, 64'h2, "pop zero at level 0");
    @(posedge clk_sys_in);
    current_priv_level_in <= 2'h1;
    tick();
    chk(io_allowed_out, 1'b0, "io refused");
  endtask : test_system

  task automatic test_task_link();
    // Return loads resume and v86; resume then holds off the breakpoint
    do_op(cpu_flags_pkg::OP_INT_RETURN, cpu_flags_pkg::SZ_8, 0, 0, 32'h30000);
    chk(v86_mode_out, 1'b1, "v86 set");
    tick();
    chk(debug_trap_out, 1'b0, "breakpoint held off");
    do_op(cpu_flags_pkg::OP_TASK_LINK, cpu_flags_pkg::SZ_8, 0, 0, 1);
    chk(wide_flags_out[14], 1'b1, "task linked");
    do_op(cpu_flags_pkg::OP_TASK_LINK, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(wide_flags_out[14], 1'b0, "task unlinked");
  endtask : test_task_link

  task automatic test_pointer();
    redir_v = 1'b1;
    tgt_v = 64'h0000_7fff_0000_1000;
    do_op(cpu_flags_pkg::OP_NONE, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(instr_pointer_out, tgt_v, "redirect");
    redir_v = 1'b0;
    len_v = 4'h3;
    disp_v = 32'hffff_fff0;
    do_op(cpu_flags_pkg::OP_NONE, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(instr_pointer_out, 64'h0000_7fff_0000_1003, "advance");
    chk(rel_addr_out, 64'h0000_7fff_0000_0ff3, "relative address");
    @(posedge clk_sys_in);
    wide_mode_in <= 1'b0;
    redir_v = 1'b1;
    tgt_v = 64'h0000_0000_ffff_fffe;
    do_op(cpu_flags_pkg::OP_NONE, cpu_flags_pkg::SZ_8, 0, 0, 0);
    redir_v = 1'b0;
    len_v = 4'h4;
    do_op(cpu_flags_pkg::OP_NONE, cpu_flags_pkg::SZ_8, 0, 0, 0);
    chk(instr_pointer_out, 64'h2, "narrow pointer wraps");
  endtask : test_pointer

  task automatic test_init();
    do_op(cpu_flags_pkg::OP_SET_DIR, cpu_flags_pkg::SZ_8, 0, 0, 0);
    @(posedge clk_sys_in);
    init_in <= 1'b1;
    @(posedge clk_sys_in);
    init_in <= 1'b0;
    #1;
    chk(wide_flags_out, 64'h2, "flags after init");
    chk(instr_pointer_out, 64'h0, "pointer after init");
  endtask : test_init

  // Main sequence: reset for two cycles, then each scenario in turn
  initial begin
    @(posedge clk_sys_in);
    #1;
    test_reset();
    @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    test_arith();
    test_carry_ops();
    test_direction();
    test_system();
    test_task_link();
    test_pointer();
    test_init();
    wrap_up();
  end
endmodule : cpu_flags_ip_tb
